// ===== lbdor_pkg.sv
package lbdor_pkg;
  localparam logic [11:0] IDX_EXTRA = 12'h020B;
  localparam logic [11:0] IDX_SYNC = 12'h020F;
  localparam logic [11:0] IDX_DDC = 12'h0210;
  localparam logic [11:0] IDX_THR_I = 12'h0211;
  localparam logic [11:0] IDX_THR_Q = 12'h0212;
  localparam logic [11:0] IDX_CTRL = 12'h0300;
  localparam logic [11:0] IDX_FRAME = 12'h0301;
  localparam logic [11:0] IDX_STAT = 12'h0302;
  localparam logic [11:0] IDX_MASK = 12'h0303;
  localparam logic [13:0] ADDR_EXTRA = {IDX_EXTRA, 2'b00};
  localparam logic [13:0] ADDR_SYNC = {IDX_SYNC, 2'b00};
  localparam logic [13:0] ADDR_DDC = {IDX_DDC, 2'b00};
  localparam logic [13:0] ADDR_THR_I = {IDX_THR_I, 2'b00};
  localparam logic [13:0] ADDR_THR_Q = {IDX_THR_Q, 2'b00};
  localparam logic [13:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [13:0] ADDR_FRAME = {IDX_FRAME, 2'b00};
  localparam logic [13:0] ADDR_STAT = {IDX_STAT, 2'b00};
  localparam logic [13:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [7:0] RST_EXTRA = 8'h00;
  localparam logic [1:0] RST_SYNC = 2'h0;
  localparam logic RST_FILTER_GAIN_A = 1'b0;
  localparam logic [7:0] RST_THR_I = 8'hF2;
  localparam logic [7:0] RST_THR_Q = 8'hAB;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [5:0] RST_FRAME = 6'h00;
  localparam logic [3:0] RST_IRQ = 4'h0;
  localparam int EXTRA_SER_BIT = 0;
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_PD_BIT = 1;
  localparam int CTRL_TEST_LSB = 4;
  localparam int EV_OVR_I = 0;
  localparam int EV_OVR_Q = 1;
  localparam int EV_LIVE_WRITE = 2;
  localparam int EV_RSVD_SYNC = 3;
  localparam logic [1:0] SYNC_CRC12 = 2'h0;
  localparam logic [1:0] SYNC_FEC = 2'h2;
  localparam logic [3:0] TEST_OFF = 4'h0;
  localparam logic [3:0] TEST_RAMP_ALT = 4'h5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== lbdor_regs.sv
// Summary of operation
// - Extra-lane bits 7:1 each enable link-layer clocks of lane Bn.
// - Bit 0 at one also powers extra-lane serializers so they transmit.
// - Extra lanes run at the framing mode's rate and test pattern setting.
// - Extra-only lanes send octet ramp when test pattern select is 0 or 5.
// - Channel power-down keeps all lanes, extra ones too, inactive.
// - Serializer n is clocked only when lanes 0 to n-1 are enabled.
// - Sync-word field bits 1:0 act only in 64b/66b framing modes.
// - Sync field 0 sends CRC-12, 2 sends FEC parity, 1 and 3 reserved.
// - All sync-word command fields are sent as zero idle headers.
// - Down-converter bit 0 adds 6.02 dB filter gain, else 0 dB.
// - In-phase threshold sets over-range bit 0 carried with I samples.
// - Quadrature threshold sets over-range bit 1 carried with Q samples.
// - Threshold level equals value over 256 of full scale.
//
// Chosen here: register access over AXI4-Lite.
module lbdor_regs #(
  parameter int LANES = 8,
  parameter int SMP_W = 16,
  parameter int CMD_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [13:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [13:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [LANES-1:0] MODE_LANES,
  input wire logic MODE_64B66B,
  output logic [5:0] FRAMING_MODE_SELECT,
  output logic [3:0] TEST_PATTERN_SELECT,
  output logic [LANES-1:0] LANE_CLK_EN,
  output logic [LANES-1:0] LANE_SER_EN,
  output logic [LANES-1:0] LANE_RAMP,
  output logic SYNC_CRC_EN,
  output logic SYNC_FEC_EN,
  output logic [CMD_W-1:0] SYNC_CMD,
  input wire logic SAMPLE_VALID,
  input wire logic [SMP_W-1:0] I_IN,
  input wire logic [SMP_W-1:0] Q_IN,
  output logic OUT_VALID,
  output logic [SMP_W-1:0] I_OUT,
  output logic [SMP_W-1:0] Q_OUT,
  output logic OVR_I,
  output logic OVR_Q,
  output logic IRQ
);
  logic [13:0] aw_addr_ff;
  logic aw_hold_ff;
  logic [7:0] w_data_ff;
  logic w_strb_ff;
  logic w_hold_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rdata_ff;
  logic [7:0] extra_ff;
  logic [1:0] sync_ff;
  logic filter_gain_a_ff;
  logic [7:0] thr_i_ff;
  logic [7:0] thr_q_ff;
  logic [7:0] ctrl_ff;
  logic [5:0] frame_ff;
  logic [3:0] stat_ff;
  logic [3:0] mask_ff;
  logic [LANES-1:0] lane_clk_ff;
  logic [LANES-1:0] lane_ser_ff;
  logic [LANES-1:0] lane_ramp_ff;
  logic crc_ff;
  logic fec_ff;
  logic out_valid_ff;
  logic [SMP_W-1:0] smp_ff [2];
  logic [1:0] hit_ff;

  // Write channel: address and data are caught independently, then committed together.
  wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_fire = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire [11:0] wr_idx = aw_addr_ff[13:2];
  wire hit_extra = wr_idx == lbdor_pkg::ADDR_EXTRA[13:2];
  wire hit_sync = wr_idx == lbdor_pkg::ADDR_SYNC[13:2];
  wire hit_ddc = wr_idx == lbdor_pkg::ADDR_DDC[13:2];
  wire hit_thr_i = wr_idx == lbdor_pkg::ADDR_THR_I[13:2];
  wire hit_thr_q = wr_idx == lbdor_pkg::ADDR_THR_Q[13:2];
  wire hit_ctrl = wr_idx == lbdor_pkg::ADDR_CTRL[13:2];
  wire hit_frame = wr_idx == lbdor_pkg::ADDR_FRAME[13:2];
  wire hit_stat = wr_idx == lbdor_pkg::ADDR_STAT[13:2];
  wire hit_mask = wr_idx == lbdor_pkg::ADDR_MASK[13:2];
  wire wr_mapped = hit_extra | hit_sync | hit_ddc | hit_thr_i | hit_thr_q | hit_ctrl | hit_frame | hit_stat | hit_mask;
  wire wr_en = wr_fire & w_strb_ff;
  wire we_extra = wr_en & hit_extra;
  wire we_sync = wr_en & hit_sync;
  wire we_stat = wr_en & hit_stat;

  assign S_AXI_AWREADY = ~aw_hold_ff & ~bvalid_ff;
  assign S_AXI_WREADY = ~w_hold_ff & ~bvalid_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= lbdor_pkg::RESP_OKAY;
      aw_addr_ff <= 14'h0000;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
    end else begin
      if (aw_hs) aw_addr_ff <= S_AXI_AWADDR;
      if (w_hs) begin
        w_data_ff <= S_AXI_WDATA[7:0];
        w_strb_ff <= S_AXI_WSTRB[0];
      end
      aw_hold_ff <= (aw_hold_ff | aw_hs) & ~wr_fire;
      w_hold_ff <= (w_hold_ff | w_hs) & ~wr_fire;
      if (wr_fire) bresp_ff <= wr_mapped ? lbdor_pkg::RESP_OKAY : lbdor_pkg::RESP_SLVERR;
      bvalid_ff <= wr_fire | (bvalid_ff & ~S_AXI_BREADY);
    end
  end

  // Read channel: one read in flight, answered on the cycle after the address is taken.
  wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  wire [11:0] rd_idx = S_AXI_ARADDR[13:2];
  wire rd_extra = rd_idx == lbdor_pkg::ADDR_EXTRA[13:2];
  wire rd_sync = rd_idx == lbdor_pkg::ADDR_SYNC[13:2];
  wire rd_ddc = rd_idx == lbdor_pkg::ADDR_DDC[13:2];
  wire rd_thr_i = rd_idx == lbdor_pkg::ADDR_THR_I[13:2];
  wire rd_thr_q = rd_idx == lbdor_pkg::ADDR_THR_Q[13:2];
  wire rd_ctrl = rd_idx == lbdor_pkg::ADDR_CTRL[13:2];
  wire rd_frame = rd_idx == lbdor_pkg::ADDR_FRAME[13:2];
  wire rd_stat = rd_idx == lbdor_pkg::ADDR_STAT[13:2];
  wire rd_mask = rd_idx == lbdor_pkg::ADDR_MASK[13:2];
  wire rd_mapped = rd_extra | rd_sync | rd_ddc | rd_thr_i | rd_thr_q | rd_ctrl | rd_frame | rd_stat | rd_mask;
  wire [7:0] rd_mux = ({8{rd_extra}} & extra_ff) | ({8{rd_sync}} & {6'h00, sync_ff})
    | ({8{rd_ddc}} & {7'h00, filter_gain_a_ff}) | ({8{rd_thr_i}} & thr_i_ff) | ({8{rd_thr_q}} & thr_q_ff)
    | ({8{rd_ctrl}} & ctrl_ff) | ({8{rd_frame}} & {2'h0, frame_ff})
    | ({8{rd_stat}} & {4'h0, stat_ff}) | ({8{rd_mask}} & {4'h0, mask_ff});

  assign S_AXI_ARREADY = ~rvalid_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign S_AXI_RDATA = {24'h00_0000, rdata_ff};

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= lbdor_pkg::RESP_OKAY;
      rdata_ff <= 8'h00;
    end else begin
      if (ar_hs) begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_mapped ? lbdor_pkg::RESP_OKAY : lbdor_pkg::RESP_SLVERR;
      end
      rvalid_ff <= ar_hs | (rvalid_ff & ~S_AXI_RREADY);
    end
  end

  // Configuration storage; reserved bits are not stored and read as zero.
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      extra_ff <= lbdor_pkg::RST_EXTRA;
      sync_ff <= lbdor_pkg::RST_SYNC;
      filter_gain_a_ff <= lbdor_pkg::RST_FILTER_GAIN_A;
      thr_i_ff <= lbdor_pkg::RST_THR_I;
      thr_q_ff <= lbdor_pkg::RST_THR_Q;
      ctrl_ff <= lbdor_pkg::RST_CTRL;
      frame_ff <= lbdor_pkg::RST_FRAME;
      mask_ff <= lbdor_pkg::RST_IRQ;
    end else begin
      if (we_extra) extra_ff <= w_data_ff;
      if (we_sync) sync_ff <= w_data_ff[1:0];
      if (wr_en & hit_ddc) filter_gain_a_ff <= w_data_ff[0];
      if (wr_en & hit_thr_i) thr_i_ff <= w_data_ff;
      if (wr_en & hit_thr_q) thr_q_ff <= w_data_ff;
      if (wr_en & hit_ctrl) ctrl_ff <= {w_data_ff[7:4], 2'b00, w_data_ff[1:0]};
      if (wr_en & hit_frame) frame_ff <= w_data_ff[5:0];
      if (wr_en & hit_mask) mask_ff <= w_data_ff[3:0];
    end
  end

  wire link_en = ctrl_ff[lbdor_pkg::CTRL_LINK_EN_BIT];
  wire link_up = link_en & ~ctrl_ff[lbdor_pkg::CTRL_PD_BIT];
  wire [3:0] test_sel = ctrl_ff[lbdor_pkg::CTRL_TEST_LSB +: 4];
  wire ramp_test = (test_sel == lbdor_pkg::TEST_OFF) | (test_sel == lbdor_pkg::TEST_RAMP_ALT);
  wire ser_scope = extra_ff[lbdor_pkg::EXTRA_SER_BIT];

  // Events are sticky; a new event in the clearing cycle keeps its bit set.
  wire [3:0] events;
  assign events[lbdor_pkg::EV_OVR_I] = hit_ff[0] & out_valid_ff;
  assign events[lbdor_pkg::EV_OVR_Q] = hit_ff[1] & out_valid_ff;
  assign events[lbdor_pkg::EV_LIVE_WRITE] = (we_extra | we_sync) & link_en;
  assign events[lbdor_pkg::EV_RSVD_SYNC] = we_sync & w_data_ff[0];
  wire [3:0] stat_clr = we_stat ? w_data_ff[3:0] : 4'h0;
  wire [3:0] nxt_stat = (stat_ff & ~stat_clr) | events;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stat_ff <= lbdor_pkg::RST_IRQ;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign IRQ = |(stat_ff & mask_ff);

  // Lane enables: serializer n also needs every lower lane clocked.
  wire [LANES-1:0] lane_clk;
  wire [LANES-1:0] lane_ser;
  wire [LANES-1:0] lane_ramp;
  wire [LANES:0] lower_ok;
  assign lower_ok[0] = 1'b1;
  for (genvar n = 0; n < LANES; n++) begin : g_lane
    wire extra_req = (n != 0) & extra_ff[n];
    assign lane_clk[n] = link_up & (MODE_LANES[n] | extra_req);
    assign lower_ok[n+1] = lower_ok[n] & lane_clk[n];
    assign lane_ser[n] = link_up & (MODE_LANES[n] | (extra_req & ser_scope)) & lower_ok[n];
    assign lane_ramp[n] = lane_clk[n] & ~MODE_LANES[n] & ramp_test;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      lane_clk_ff <= '0;
      lane_ser_ff <= '0;
      lane_ramp_ff <= '0;
      crc_ff <= 1'b0;
      fec_ff <= 1'b0;
    end else begin
      lane_clk_ff <= lane_clk;
      lane_ser_ff <= lane_ser;
      lane_ramp_ff <= lane_ramp;
      crc_ff <= link_up & MODE_64B66B & (sync_ff == lbdor_pkg::SYNC_CRC12);
      fec_ff <= link_up & MODE_64B66B & (sync_ff == lbdor_pkg::SYNC_FEC);
    end
  end

  assign LANE_CLK_EN = lane_clk_ff;
  assign LANE_SER_EN = lane_ser_ff;
  assign LANE_RAMP = lane_ramp_ff;
  assign FRAMING_MODE_SELECT = frame_ff;
  assign TEST_PATTERN_SELECT = test_sel;
  assign SYNC_CRC_EN = crc_ff;
  assign SYNC_FEC_EN = fec_ff;
  assign SYNC_CMD = '0;

  // Sample path: optional doubling with saturation, then magnitude against threshold.
  wire [SMP_W-1:0] smp_in [2];
  wire [7:0] thr [2];
  wire [SMP_W-1:0] smp_out [2];
  wire [1:0] hit;
  assign smp_in[0] = I_IN;
  assign smp_in[1] = Q_IN;
  assign thr[0] = thr_i_ff;
  assign thr[1] = thr_q_ff;
  for (genvar c = 0; c < 2; c++) begin : g_chan
    wire [SMP_W:0] dbl = {smp_in[c], 1'b0};
    wire ovf = dbl[SMP_W] ^ dbl[SMP_W-1];
    wire [SMP_W-1:0] sat = {dbl[SMP_W], {(SMP_W-1){~dbl[SMP_W]}}};
    wire [SMP_W-1:0] boosted = ovf ? sat : dbl[SMP_W-1:0];
    assign smp_out[c] = filter_gain_a_ff ? boosted : smp_in[c];
    wire [SMP_W-1:0] mag = smp_out[c][SMP_W-1] ? (~smp_out[c] + 1'b1) : smp_out[c];
    wire [SMP_W-1:0] level = {1'b0, thr[c], {(SMP_W-9){1'b0}}};
    assign hit[c] = SAMPLE_VALID & (mag >= level);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      out_valid_ff <= 1'b0;
      smp_ff[0] <= '0;
      smp_ff[1] <= '0;
      hit_ff <= 2'b00;
    end else begin
      out_valid_ff <= SAMPLE_VALID;
      smp_ff[0] <= smp_out[0];
      smp_ff[1] <= smp_out[1];
      hit_ff <= hit;
    end
  end

  assign OUT_VALID = out_valid_ff;
  assign I_OUT = smp_ff[0];
  assign Q_OUT = smp_ff[1];
  assign OVR_I = hit_ff[0];
  assign OVR_Q = hit_ff[1];

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  wire [LANES-1:0] chain_bad;
  for (genvar k = 1; k < LANES; k++) begin : g_chk
    assign chain_bad[k] = lane_ser_ff[k] & ~(&lane_clk_ff[k-1:0]);
  end
  assign chain_bad[0] = 1'b0;

  sequence s_extra_write;
    we_extra ##1 1'b1;
  endsequence
  property p_extra_store;
    s_extra_write |-> extra_ff == $past(w_data_ff);
  endproperty
  a_extra_store: assert property (p_extra_store) else $error("extra lane register not updated");
  property p_scope_off;
    (link_up && extra_ff[1] && !MODE_LANES[1] && !ser_scope) |=> (LANE_CLK_EN[1] && !LANE_SER_EN[1]);
  endproperty
  a_scope_off: assert property (p_scope_off) else $error("extra serializer on with scope bit clear");
  property p_live_write;
    (we_extra && link_en) |=> stat_ff[lbdor_pkg::EV_LIVE_WRITE];
  endproperty
  a_live_write: assert property (p_live_write) else $error("live write event missed");
  property p_ramp;
    (link_up && extra_ff[2] && !MODE_LANES[2] && test_sel == lbdor_pkg::TEST_RAMP_ALT) |=> LANE_RAMP[2];
  endproperty
  a_ramp: assert property (p_ramp) else $error("extra lane not sending ramp");
  property p_pd;
    ctrl_ff[lbdor_pkg::CTRL_PD_BIT] |=> (LANE_CLK_EN == '0 && LANE_SER_EN == '0);
  endproperty
  a_pd: assert property (p_pd) else $error("lane active while powered down");
  property p_chain;
    chain_bad == '0;
  endproperty
  a_chain: assert property (p_chain) else $error("serializer clocked without lower lanes");
  property p_sync_gate;
    !MODE_64B66B |=> !(SYNC_CRC_EN || SYNC_FEC_EN);
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync word active outside 64b/66b");
  property p_fec;
    (link_up && MODE_64B66B && sync_ff == lbdor_pkg::SYNC_FEC) |=> (SYNC_FEC_EN && !SYNC_CRC_EN);
  endproperty
  a_fec: assert property (p_fec) else $error("fec select not honoured");
  sequence s_small_filter_gain_a;
    SAMPLE_VALID && filter_gain_a_ff && (I_IN[SMP_W-1] == I_IN[SMP_W-2]);
  endsequence
  property p_filter_gain_a;
    s_small_filter_gain_a |=> (OUT_VALID && I_OUT == {$past(I_IN[SMP_W-2:0]), 1'b0});
  endproperty
  a_filter_gain_a: assert property (p_filter_gain_a) else $error("gain filter_gain_a output wrong");
  property p_ovr_i;
    (SAMPLE_VALID && !filter_gain_a_ff && !I_IN[SMP_W-1] && I_IN[SMP_W-2 -: 8] >= thr_i_ff) |=> OVR_I;
  endproperty
  a_ovr_i: assert property (p_ovr_i) else $error("in-phase over-range missed");
  property p_ovr_q;
    (SAMPLE_VALID && !filter_gain_a_ff && !Q_IN[SMP_W-1] && Q_IN[SMP_W-2 -: 8] < thr_q_ff) |=> !OVR_Q;
  endproperty
  a_ovr_q: assert property (p_ovr_q) else $error("quadrature over-range false hit");
  property p_set_wins;
    (events[lbdor_pkg::EV_OVR_I] && stat_clr[lbdor_pkg::EV_OVR_I]) |=> stat_ff[lbdor_pkg::EV_OVR_I];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
endmodule

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic b;
    logic [15:0] i, q, ei, eq;
    logic oi, oq;
  } lbdor_smp_s;
  typedef struct packed {
    logic [7:0] extra, ctrl, mode, clk, ser, ramp;
  } lbdor_lane_s;
  logic SYS_CLK, RESET, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [13:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB, TEST_PATTERN_SELECT, strb;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [7:0] MODE_LANES, LANE_CLK_EN, LANE_SER_EN, LANE_RAMP, SYNC_CMD;
  logic [5:0] FRAMING_MODE_SELECT;
  logic MODE_64B66B, SYNC_CRC_EN, SYNC_FEC_EN, SAMPLE_VALID, OUT_VALID, OVR_I, OVR_Q, IRQ, filter_gain_a;
  logic [15:0] I_IN, Q_IN, I_OUT, Q_OUT;
  int fail_count = 0;
  int compares = 0;
  // Thresholds at reset scale to 0x7900 (I) and 0x5580 (Q) on 16-bit samples.
  lbdor_smp_s smp_rows [6] = '{
    '{1'b0, 16'h7900, 16'h557F, 16'h7900, 16'h557F, 1'b1, 1'b0},
    '{1'b0, 16'h78FF, 16'hAA80, 16'h78FF, 16'hAA80, 1'b0, 1'b1},
    '{1'b0, 16'h8000, 16'hAA81, 16'h8000, 16'hAA81, 1'b1, 1'b0},
    '{1'b1, 16'h3C80, 16'h2AC0, 16'h7900, 16'h5580, 1'b1, 1'b1},
    '{1'b1, 16'h4000, 16'hBFFF, 16'h7FFF, 16'h8000, 1'b1, 1'b1},
    '{1'b1, 16'h3C7F, 16'h0000, 16'h78FE, 16'h0000, 1'b0, 1'b0}};
  lbdor_lane_s lane_rows [8] = '{
    '{8'h0D, 8'h01, 8'h03, 8'h0F, 8'h0F, 8'h0C},
    '{8'h11, 8'h01, 8'h03, 8'h13, 8'h03, 8'h10},
    '{8'h0E, 8'h51, 8'h01, 8'h0F, 8'h01, 8'h0E},
    '{8'h0D, 8'h41, 8'h03, 8'h0F, 8'h0F, 8'h00},
    '{8'h0D, 8'h03, 8'h03, 8'h00, 8'h00, 8'h00},
    '{8'h0D, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00},
    '{8'hFF, 8'h01, 8'h01, 8'hFF, 8'hFF, 8'hFE},
    '{8'h00, 8'h21, 8'h0F, 8'h0F, 8'h0F, 8'h00}};

  lbdor_regs lbdor_regs_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .MODE_LANES(MODE_LANES), .MODE_64B66B(MODE_64B66B),
    .FRAMING_MODE_SELECT(FRAMING_MODE_SELECT), .TEST_PATTERN_SELECT(TEST_PATTERN_SELECT),
    .LANE_CLK_EN(LANE_CLK_EN), .LANE_SER_EN(LANE_SER_EN), .LANE_RAMP(LANE_RAMP),
    .SYNC_CRC_EN(SYNC_CRC_EN), .SYNC_FEC_EN(SYNC_FEC_EN), .SYNC_CMD(SYNC_CMD),
    .SAMPLE_VALID(SAMPLE_VALID), .I_IN(I_IN), .Q_IN(Q_IN), .OUT_VALID(OUT_VALID), .I_OUT(I_OUT),
    .Q_OUT(Q_OUT), .OVR_I(OVR_I), .OVR_Q(OVR_Q), .IRQ(IRQ));

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bail(input int n);
    if (n >= 40) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d, input logic [1:0] er = lbdor_pkg::RESP_OKAY);
    logic aw, w;
    int n;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA <= {24'h00_0000, d};
    S_AXI_WSTRB <= strb;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge SYS_CLK);
      if (!aw && !w && S_AXI_BVALID) break;
      if (aw && S_AXI_AWREADY) begin
        aw = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w && S_AXI_WREADY) begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end
    S_AXI_BREADY <= 1'b0;
    bail(n);
    check(S_AXI_BRESP, er);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] ed, input logic [1:0] er = lbdor_pkg::RESP_OKAY);
    logic ar;
    int n;
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    ar = 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge SYS_CLK);
      if (!ar && S_AXI_RVALID) break;
      if (ar && S_AXI_ARREADY) begin
        ar = 1'b0;
        S_AXI_ARVALID <= 1'b0;
      end
    end
    S_AXI_RREADY <= 1'b0;
    bail(n);
    check(S_AXI_RDATA, ed);
    check(S_AXI_RRESP, er);
  endtask

  task automatic settle;
    repeat (2) @(posedge SYS_CLK);
    #1;
  endtask

  initial begin
    RESET = 1'b1;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    S_AXI_AWADDR = 14'h0000;
    S_AXI_ARADDR = 14'h0000;
    S_AXI_WDATA = 32'h0000_0000;
    S_AXI_WSTRB = 4'h1;
    strb = 4'h1;
    MODE_LANES = 8'h00;
    MODE_64B66B = 1'b0;
    SAMPLE_VALID = 1'b0;
    I_IN = 16'h0000;
    Q_IN = 16'h0000;
    filter_gain_a = 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RESET <= 1'b0;
    #1;
    check({S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID, S_AXI_RVALID, IRQ}, 6'b111000);
    rd(lbdor_pkg::ADDR_EXTRA, 32'h0000_0000);
    rd(lbdor_pkg::ADDR_SYNC, 32'h0000_0000);
    rd(lbdor_pkg::ADDR_DDC, 32'h0000_0000);
    rd(lbdor_pkg::ADDR_THR_I, 32'h0000_00F2);
    rd(lbdor_pkg::ADDR_THR_Q, 32'h0000_00AB);
    rd(lbdor_pkg::ADDR_STAT, 32'h0000_0000);
    rd(lbdor_pkg::ADDR_MASK, 32'h0000_0000);
    foreach (smp_rows[k]) begin
      if (smp_rows[k].b !== filter_gain_a) begin
        // Filter_gain_a rows assume the down-converter has already removed the negative image.
        wr(lbdor_pkg::ADDR_DDC, {7'h00, smp_rows[k].b});
        filter_gain_a = smp_rows[k].b;
      end
      @(posedge SYS_CLK);
      SAMPLE_VALID <= 1'b1;
      I_IN <= smp_rows[k].i;
      Q_IN <= smp_rows[k].q;
      @(posedge SYS_CLK);
      SAMPLE_VALID <= 1'b0;
      #1;
      check(OUT_VALID, 1'b1);
      check({I_OUT, Q_OUT}, {smp_rows[k].ei, smp_rows[k].eq});
      check(OVR_I, smp_rows[k].oi);
      check(OVR_Q, smp_rows[k].oq);
    end
    wr(lbdor_pkg::ADDR_THR_I, 8'h5A);
    wr(lbdor_pkg::ADDR_THR_Q, 8'h3C);
    strb = 4'h0;
    wr(lbdor_pkg::ADDR_THR_I, 8'h77);
    strb = 4'h1;
    rd(lbdor_pkg::ADDR_THR_I, 32'h0000_005A);
    rd(lbdor_pkg::ADDR_THR_Q, 32'h0000_003C);
    rd(lbdor_pkg::ADDR_DDC, 32'h0000_0001);
    wr(14'h0010, 8'h55, lbdor_pkg::RESP_SLVERR);
    rd(14'h0010, 32'h0000_0000, lbdor_pkg::RESP_SLVERR);
    foreach (lane_rows[k]) begin
      wr(lbdor_pkg::ADDR_CTRL, 8'h00);
      wr(lbdor_pkg::ADDR_EXTRA, lane_rows[k].extra);
      MODE_LANES <= lane_rows[k].mode;
      wr(lbdor_pkg::ADDR_CTRL, lane_rows[k].ctrl);
      settle();
      check(LANE_CLK_EN, lane_rows[k].clk);
      check(LANE_SER_EN, lane_rows[k].ser);
      check(LANE_RAMP, lane_rows[k].ramp);
      check(TEST_PATTERN_SELECT, lane_rows[k].ctrl[7:4]);
    end
    wr(lbdor_pkg::ADDR_FRAME, 8'h2A);
    settle();
    check(FRAMING_MODE_SELECT, 6'h2A);
    for (int m = 0; m < 2; m++) begin
      for (int v = 0; v < 4; v++) begin
        wr(lbdor_pkg::ADDR_CTRL, 8'h00);
        wr(lbdor_pkg::ADDR_SYNC, 8'(v));
        wr(lbdor_pkg::ADDR_CTRL, 8'h01);
        MODE_64B66B <= m[0];
        settle();
        check(SYNC_CRC_EN, m == 1 && v == 0);
        check(SYNC_FEC_EN, m == 1 && v == 2);
        check(SYNC_CMD, 8'h00);
      end
    end
    rd(lbdor_pkg::ADDR_STAT, 32'h0000_000B);
    check(IRQ, 1'b0);
    wr(lbdor_pkg::ADDR_MASK, 8'h08);
    settle();
    check(IRQ, 1'b1);
    wr(lbdor_pkg::ADDR_STAT, 8'h08);
    settle();
    check(IRQ, 1'b0);
    rd(lbdor_pkg::ADDR_STAT, 32'h0000_0003);
    wr(lbdor_pkg::ADDR_STAT, 8'h03);
    rd(lbdor_pkg::ADDR_STAT, 32'h0000_0000);
    // A sample event that lands in the clearing cycle must keep its status bit.
    fork
      wr(lbdor_pkg::ADDR_STAT, 8'h01);
      begin
        @(posedge SYS_CLK);
        SAMPLE_VALID <= 1'b1;
        I_IN <= 16'h7FFF;
        @(posedge SYS_CLK);
        SAMPLE_VALID <= 1'b0;
      end
    join
    rd(lbdor_pkg::ADDR_STAT, 32'h0000_0001);
    wr(lbdor_pkg::ADDR_STAT, 8'h01);
    rd(lbdor_pkg::ADDR_STAT, 32'h0000_0000);
    wr(lbdor_pkg::ADDR_EXTRA, 8'h00);
    wr(lbdor_pkg::ADDR_MASK, 8'h04);
    settle();
    check(IRQ, 1'b1);
    rd(lbdor_pkg::ADDR_STAT, 32'h0000_0004);
    wr(lbdor_pkg::ADDR_MASK, 8'h00);
    settle();
    check(IRQ, 1'b0);
    wr(lbdor_pkg::ADDR_EXTRA, 8'hFF);
    @(posedge SYS_CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RESET <= 1'b0;
    #1;
    check({S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID, S_AXI_RVALID, IRQ}, 6'b111000);
    check({LANE_CLK_EN, LANE_SER_EN, LANE_RAMP}, 24'h00_0000);
    rd(lbdor_pkg::ADDR_THR_I, 32'h0000_00F2);
    rd(lbdor_pkg::ADDR_EXTRA, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
